// [verilog/pmd_defs.svh]
// Purpose: offsets, field positions and reset values of the module-disable bank
// Assumes: byte addresses on the plain register port, 16-bit word offset
// Notes:   definitions only
`ifndef PMD_DEFS_SVH
`define PMD_DEFS_SVH

// ----------------------------------------------------------------------------
// register map
// ----------------------------------------------------------------------------
`define PMD_ADDR_W          16
`define PMD_OFS_ANALOG      16'hF240
`define PMD_OFS_COMPARATORS 16'hF250
`define PMD_OFS_CAPCOMP     16'hF260
`define PMD_OFS_TIMERS      16'hF270
`define PMD_OFS_SERIAL      16'hF280
`define PMD_OFS_MISC        16'hF290
`define PMD_OFS_CONFIG_CONTROL_REG      16'hF000
`define PMD_OFS_UNLOCK      16'hF010
`define PMD_ALIAS_CLR       2'h1
`define PMD_ALIAS_SET       2'h2
`define PMD_ALIAS_INV       2'h3

// ----------------------------------------------------------------------------
// fields and reset values
// ----------------------------------------------------------------------------
`define PMD_LOCK_BIT        12
`define PMD_ONE_WAY_BIT     28
`define PMD_RESET_VAL       32'h0000_0000
`define PMD_CONFIG_CONTROL_REG_RESET    32'h0000_0000
`define PMD_KEY_1           32'hAA99_6655
`define PMD_KEY_2           32'h5566_99AA
// implemented bits of each disable register
`define PMD_MASK_ANALOG     32'h0000_1101
`define PMD_MASK_COMPARATORS 32'h0000_0007
`define PMD_MASK_CAPCOMP    32'h001F_001F
`define PMD_MASK_TIMERS     32'h0000_001F
`define PMD_MASK_SERIAL     32'h0103_0303
`define PMD_MASK_MISC       32'h0001_0003

`endif

// [verilog/pmd_pkg.sv]
// Purpose: types shared by the module-disable bank
// Assumes: pmd_defs.svh holds the numbers
// Notes:   none
package pmd_pkg;
   typedef struct packed {
      logic [15:0] addr;
      logic [31:0] wdata;
      logic        wr;
      logic        rd;
   } pmd_req_s;

   typedef enum logic [1:0] {
      PMD_KEY_IDLE = 2'b00,
      PMD_KEY_HALF = 2'b01,
      PMD_KEY_OPEN = 2'b10
   } pmd_key_e;
endpackage : pmd_pkg

// [verilog/pmd_lock_regs.sv]
// Purpose: six module-disable registers with write lock and one-way option
// Assumes: one clock, synchronous active-high reset, plain register port
// Notes:   unlock is two key words written back to back to the unlock register
//
// How it works
// R1 - locked writes to disable registers are dropped
// R2 - lock bit 12 of config control
// R3 - lock bit changes only after unlock sequence
// R4 - one-way option forbids clearing set lock
// R5 - one-way plus lock refuses unlock sequence
// R6 - only reset clears a sticky lock
// R7 - unimplemented disable bits read zero
// R8 - clear, set, invert aliases at 4,8,C
// R9 - set disable bit gates peripheral clock
// R10 - one disables, zero enables, default zero
// R11 - software stops peripheral before disabling it
// R12 - reset zeroes all disable registers
//
// Local design decision: the plain strobed port.
`timescale 1ns/1ns
`include "pmd_defs.svh"

module pmd_lock_regs (
   // clock and reset
   input  wire logic                clk_i,
   input  wire logic                rst_i,
   // register port
   input  wire pmd_pkg::pmd_req_s   req_i,
   output logic [31:0]              rdata_o,
   // configuration word bit, static after reset
   input  wire logic                lock_one_way_option_i,
   // peripheral clock gates and write lock status
   output logic [5:0][31:0]         module_disable_o,
   output logic                     disable_write_lock_o
);
   import pmd_pkg::*;

   // ----------------------------------------------------------------------------
   // storage and decode
   // ----------------------------------------------------------------------------
   localparam logic [5:0][15:0] BASES = {`PMD_OFS_MISC, `PMD_OFS_SERIAL, `PMD_OFS_TIMERS,
                                         `PMD_OFS_CAPCOMP, `PMD_OFS_COMPARATORS, `PMD_OFS_ANALOG};
   localparam logic [5:0][31:0] MASKS = {`PMD_MASK_MISC, `PMD_MASK_SERIAL, `PMD_MASK_TIMERS,
                                         `PMD_MASK_CAPCOMP, `PMD_MASK_COMPARATORS, `PMD_MASK_ANALOG};

   logic [5:0][31:0] disable_q;
   logic [5:0][31:0] next_disable;
   logic [5:0]       hit;
   logic             lock;
   logic             one_way_a;
   logic             one_way;
   pmd_key_e         key;
   pmd_key_e         next_key;
   logic [31:0]      next_rdata;

   wire [15:0] word_addr = {req_i.addr[15:4], 4'h0};
   wire [1:0]  alias_sel = req_i.addr[3:2];
   wire        cfg_hit   = req_i.addr == `PMD_OFS_CONFIG_CONTROL_REG;
   wire        key_hit   = req_i.wr && req_i.addr == `PMD_OFS_UNLOCK;
   // unlock is refused outright when the lock has become sticky
   wire        sticky    = one_way && lock;                              // [R5]
   wire        open_ok   = key == PMD_KEY_OPEN && !sticky;               // [R3] [R5]
   wire        lock_wr   = req_i.wr && cfg_hit && open_ok;               // [R3]
   wire        new_lock  = req_i.wdata[`PMD_LOCK_BIT];                   // [R2]
   // one-way: a clear is ignored once set
   wire        next_lock = lock_wr ? (new_lock | (lock & one_way)) : lock; // [R4]

   // one-way option passes two flops since it comes from outside
   always_ff @(posedge clk_i) begin
      one_way_a <= lock_one_way_option_i;
      one_way   <= one_way_a;
   end

   // ----------------------------------------------------------------------------
   // register update, one slice per disable register
   // ----------------------------------------------------------------------------
   genvar g;
   generate
      for (g = 0; g < 6; g++) begin : g_reg
         assign hit[g] = word_addr == BASES[g];
         always_comb begin
            next_disable[g] = disable_q[g];
            if (req_i.wr && hit[g] && !lock) begin                      // [R1] [R2]
               case (alias_sel)                                         // [R8]
                  `PMD_ALIAS_CLR: next_disable[g] = disable_q[g] & ~req_i.wdata;
                  `PMD_ALIAS_SET: next_disable[g] = disable_q[g] | req_i.wdata;
                  `PMD_ALIAS_INV: next_disable[g] = disable_q[g] ^ req_i.wdata;
                  default:        next_disable[g] = req_i.wdata;
               endcase
               next_disable[g] = next_disable[g] & MASKS[g];             // [R7]
            end
         end
      end
   endgenerate

   // unlock key sequence; any other write to the key register restarts it
   // an open key closes on the next key write, which may start a fresh sequence
   always_comb begin
      next_key = key;
      if (sticky) begin
         next_key = PMD_KEY_IDLE;                                       // [R5]
      end else if (key_hit) begin
         case (key)
            PMD_KEY_IDLE: next_key = req_i.wdata == `PMD_KEY_1 ? PMD_KEY_HALF : PMD_KEY_IDLE;
            PMD_KEY_HALF: next_key = req_i.wdata == `PMD_KEY_2 ? PMD_KEY_OPEN : PMD_KEY_IDLE;
            PMD_KEY_OPEN: next_key = req_i.wdata == `PMD_KEY_1 ? PMD_KEY_HALF : PMD_KEY_IDLE;
            default:      next_key = PMD_KEY_IDLE;
         endcase
      end
   end

   always_ff @(posedge clk_i) begin
      if (rst_i) begin
         disable_q <= {6{`PMD_RESET_VAL}};                              // [R12] [R10]
         lock      <= 1'b0;                                             // [R6]
         key       <= PMD_KEY_IDLE;
      end else begin
         disable_q <= next_disable;
         lock      <= next_lock;
         key       <= next_key;
      end
   end

   // ----------------------------------------------------------------------------
   // read path, one cycle after the strobe
   // ----------------------------------------------------------------------------
   always_comb begin
      next_rdata = 32'h0000_0000;
      for (int i = 0; i < 6; i++) begin
         if (hit[i] && alias_sel == 2'h0) begin
            next_rdata = disable_q[i];                                  // [R7]
         end
      end
      if (cfg_hit) begin
         next_rdata[`PMD_LOCK_BIT] = lock;                              // [R2]
      end
   end

   always_ff @(posedge clk_i) begin
      if (rst_i) begin
         rdata_o <= 32'h0000_0000;
      end else begin
         rdata_o <= req_i.rd ? next_rdata : 32'h0000_0000;
      end
   end

   // a set bit stops the peripheral clock; peripheral ignores its own bus then
   assign module_disable_o     = disable_q;                             // [R9] [R10] [R11]
   assign disable_write_lock_o = lock;

   // ----------------------------------------------------------------------------
   // checks
   // ----------------------------------------------------------------------------
   chk_locked_no_write: assert property (@(posedge clk_i) disable iff (rst_i) // [R1]
      lock && !lock_wr |=> $stable(disable_q)) else $error("disable register changed while locked");

   chk_lock_needs_key: assert property (@(posedge clk_i) disable iff (rst_i) // [R3]
      key != PMD_KEY_OPEN |=> $stable(lock)) else $error("lock changed without unlock");

   chk_one_way_hold: assert property (@(posedge clk_i) disable iff (rst_i) // [R4]
      lock && one_way |=> lock) else $error("sticky lock cleared");

   chk_sticky_no_open: assert property (@(posedge clk_i) disable iff (rst_i) // [R5]
      lock && one_way && !key_hit |=> key == PMD_KEY_IDLE) else $error("unlock ran while sticky");

   chk_reset_clear: assert property (@(posedge clk_i) // [R6]
      rst_i |=> !lock && disable_q == '0) else $error("reset left state");

   chk_unimpl_zero: assert property (@(posedge clk_i) disable iff (rst_i) // [R7]
      (disable_q[1] & ~MASKS[1]) == '0 && (disable_q[4] & ~MASKS[4]) == '0) else $error("unimplemented bit set");

   chk_set_alias: assert property (@(posedge clk_i) disable iff (rst_i) // [R8]
      req_i.wr && !lock && hit[3] && alias_sel == `PMD_ALIAS_SET
      |=> (disable_q[3] & ($past(req_i.wdata) & MASKS[3])) == ($past(req_i.wdata) & MASKS[3]))
      else $error("set alias failed");

   chk_clr_alias: assert property (@(posedge clk_i) disable iff (rst_i) // [R8]
      req_i.wr && !lock && hit[0] && alias_sel == `PMD_ALIAS_CLR
      |=> (disable_q[0] & $past(req_i.wdata)) == '0) else $error("clear alias failed");

   chk_lock_read: assert property (@(posedge clk_i) disable iff (rst_i) // [R2]
      req_i.rd && cfg_hit |=> rdata_o[`PMD_LOCK_BIT] == $past(lock)) else $error("lock bit misread");

   // ----------------------------------------------------------------------------
   // lock bit and key sequence checks
   // ----------------------------------------------------------------------------
   // lock writes only land through an open key, and never clear a sticky lock
   chk_cfg_lock_set: assert property (@(posedge clk_i) disable iff (rst_i) // [R2]
      lock_wr && new_lock |=> lock)
      else $error("honoured lock set did not land");

   chk_cfg_lock_clr: assert property (@(posedge clk_i) disable iff (rst_i) // [R2]
      lock_wr && !new_lock && !one_way |=> !lock)
      else $error("honoured lock clear did not land");

   chk_cfg_no_key: assert property (@(posedge clk_i) disable iff (rst_i) // [R3]
      req_i.wr && cfg_hit && key != PMD_KEY_OPEN |=> $stable(lock))
      else $error("config write without key moved lock");

   chk_sticky_cfg_write: assert property (@(posedge clk_i) disable iff (rst_i) // [R4]
      sticky && req_i.wr && cfg_hit |=> lock)
      else $error("config write cleared sticky lock");

   chk_sticky_key_idle: assert property (@(posedge clk_i) disable iff (rst_i) // [R5]
      sticky |=> key == PMD_KEY_IDLE)
      else $error("key sequence advanced while sticky");

   chk_lock_rise_key: assert property (@(posedge clk_i) disable iff (rst_i) // [R3]
      $rose(lock) |-> $past(open_ok))
      else $error("lock rose without open key");

   chk_lock_fall_opt: assert property (@(posedge clk_i) disable iff (rst_i) // [R4]
      $fell(lock) |-> !$past(one_way))
      else $error("lock fell with one-way option on");

   // key steps: first word, second word, wrong word, idle hold
   chk_key_first: assert property (@(posedge clk_i) disable iff (rst_i) // [R3]
      key_hit && !sticky && key == PMD_KEY_IDLE && req_i.wdata == `PMD_KEY_1 |=> key == PMD_KEY_HALF)
      else $error("first key word not taken");

   chk_key_second: assert property (@(posedge clk_i) disable iff (rst_i) // [R3]
      key_hit && !sticky && key == PMD_KEY_HALF && req_i.wdata == `PMD_KEY_2 |=> key == PMD_KEY_OPEN)
      else $error("second key word not taken");

   chk_key_wrong: assert property (@(posedge clk_i) disable iff (rst_i) // [R3]
      key_hit && key == PMD_KEY_HALF && req_i.wdata != `PMD_KEY_2 |=> key == PMD_KEY_IDLE)
      else $error("wrong key word kept sequence alive");

   chk_key_hold: assert property (@(posedge clk_i) disable iff (rst_i) // [R3]
      !key_hit && !sticky |=> $stable(key))
      else $error("key state moved without key write");

   chk_reset_key: assert property (@(posedge clk_i) // [R6]
      rst_i |=> key == PMD_KEY_IDLE)
      else $error("reset left key open");

   // ----------------------------------------------------------------------------
   // disable register update checks
   // ----------------------------------------------------------------------------
   // full-value checks, so a broken alias or mask cannot hide behind a partial compare
   chk_base_write_first: assert property (@(posedge clk_i) disable iff (rst_i) // [R1]
      req_i.wr && !lock && hit[0] && alias_sel == 2'h0
      |=> disable_q[0] == ($past(req_i.wdata) & MASKS[0]))
      else $error("base write to first register wrong");

   chk_base_write_last: assert property (@(posedge clk_i) disable iff (rst_i) // [R1]
      req_i.wr && !lock && hit[5] && alias_sel == 2'h0
      |=> disable_q[5] == ($past(req_i.wdata) & MASKS[5]))
      else $error("base write to last register wrong");

   chk_inv_alias: assert property (@(posedge clk_i) disable iff (rst_i) // [R8]
      req_i.wr && !lock && hit[2] && alias_sel == `PMD_ALIAS_INV
      |=> disable_q[2] == (($past(disable_q[2]) ^ $past(req_i.wdata)) & MASKS[2]))
      else $error("invert alias wrong");

   chk_set_alias_full: assert property (@(posedge clk_i) disable iff (rst_i) // [R8]
      req_i.wr && !lock && hit[4] && alias_sel == `PMD_ALIAS_SET
      |=> disable_q[4] == (($past(disable_q[4]) | $past(req_i.wdata)) & MASKS[4]))
      else $error("set alias value wrong");

   chk_clr_alias_full: assert property (@(posedge clk_i) disable iff (rst_i) // [R8]
      req_i.wr && !lock && hit[1] && alias_sel == `PMD_ALIAS_CLR
      |=> disable_q[1] == (($past(disable_q[1]) & ~$past(req_i.wdata)) & MASKS[1]))
      else $error("clear alias value wrong");

   chk_locked_any_change: assert property (@(posedge clk_i) disable iff (rst_i) // [R1]
      !$stable(disable_q) |-> !$past(lock))
      else $error("disable register moved under lock");

   chk_unimpl_rest: assert property (@(posedge clk_i) disable iff (rst_i) // [R7]
      (disable_q[0] & ~MASKS[0]) == '0 && (disable_q[2] & ~MASKS[2]) == '0 &&
      (disable_q[3] & ~MASKS[3]) == '0 && (disable_q[5] & ~MASKS[5]) == '0)
      else $error("unimplemented bit set in other register");

   // ----------------------------------------------------------------------------
   // read path checks
   // ----------------------------------------------------------------------------
   // read data stand one cycle only; zero elsewhere keeps the bus mux simple
   chk_read_idle_zero: assert property (@(posedge clk_i) disable iff (rst_i) // [R7]
      !req_i.rd |=> rdata_o == '0)
      else $error("read data present without read");

   chk_read_timers: assert property (@(posedge clk_i) disable iff (rst_i) // [R7]
      req_i.rd && hit[3] && alias_sel == 2'h0 |=> rdata_o == $past(disable_q[3]))
      else $error("timer register misread");

   chk_read_misc: assert property (@(posedge clk_i) disable iff (rst_i) // [R7]
      req_i.rd && hit[5] && alias_sel == 2'h0 |=> rdata_o == $past(disable_q[5]))
      else $error("misc register misread");

   chk_alias_read_zero: assert property (@(posedge clk_i) disable iff (rst_i) // [R8]
      req_i.rd && alias_sel != 2'h0 |=> rdata_o == '0)
      else $error("alias address read not zero");

   chk_cfg_read_rest: assert property (@(posedge clk_i) disable iff (rst_i) // [R2]
      req_i.rd && cfg_hit |=> (rdata_o & ~32'h0000_1000) == '0)
      else $error("config read shows other bits");

   chk_reset_rdata: assert property (@(posedge clk_i) // [R12]
      rst_i |=> rdata_o == '0)
      else $error("reset left read data");

endmodule : pmd_lock_regs

// [verif/pmd_lock_regs_test.sv]
// Purpose: self-checking bench for the module-disable bank
// Assumes: offsets, keys and masks from pmd_defs.svh
// Notes:   one task per scenario, verdict in conclude
`timescale 1ns/1ns
`include "pmd_defs.svh"

module pmd_lock_regs_test;
   import pmd_pkg::*;
   logic             clk_i;
   logic             rst_i;
   pmd_req_s         req_i;
   logic [31:0]      rdata_o;
   logic             one_way;
   logic [5:0][31:0] mod_dis;
   logic             wr_lock;
   logic [31:0]      rv;
   logic [5:0][31:0] mask;
   int               failures;
   int               n_compared;

   pmd_lock_regs u_pmd_lock_regs (.clk_i(clk_i), .rst_i(rst_i), .req_i(req_i), .rdata_o(rdata_o),
      .lock_one_way_option_i(one_way), .module_disable_o(mod_dis), .disable_write_lock_o(wr_lock));

   // ---------------------------------------------------------------
   // bus and compare helpers
   // ---------------------------------------------------------------
   task automatic wr(input logic [15:0] a, input logic [31:0] d);
      @(posedge clk_i);
      req_i.addr  <= a;
      req_i.wdata <= d;
      req_i.wr    <= 1'b1;
      @(posedge clk_i);
      req_i.wr    <= 1'b0;
      #1;
   endtask : wr

   // read data stand only in the cycle after the strobe
   task automatic rd(input logic [15:0] a, output logic [31:0] d);
      @(posedge clk_i);
      req_i.addr <= a;
      req_i.rd   <= 1'b1;
      @(posedge clk_i);
      req_i.rd   <= 1'b0;
      #1 d = rdata_o;
   endtask : rd

   task automatic chk(input logic [31:0] got, input logic [31:0] exp, input string what);
      n_compared++;
      if (got !== exp) begin
         failures++;
         $display("[FAIL] %0t %s: got %h expected %h", $time, what, got, exp);
      end
   endtask : chk

   task automatic unlock();
      wr(`PMD_OFS_UNLOCK, `PMD_KEY_1);
      wr(`PMD_OFS_UNLOCK, `PMD_KEY_2);
   endtask : unlock

   task automatic do_reset();
      rst_i <= 1'b1;
      repeat (5) @(posedge clk_i);
      rst_i <= 1'b0;
   endtask : do_reset

   // ---------------------------------------------------------------
   // scenarios
   // ---------------------------------------------------------------
   task automatic t_reset();
      for (int i = 0; i < 6; i++) begin
         rd(16'hF240 + 16'(i * 16), rv);
         chk(rv, 32'h0000_0000, "reset read");
         chk(mod_dis[i], 32'h0000_0000, "reset output");
      end
      $display("done: reset values");
   endtask : t_reset

   // no peripheral runs in this bench, so setting any disable bit is safe
   task automatic t_masks();
      for (int i = 0; i < 6; i++) begin
         wr(16'hF240 + 16'(i * 16), 32'hFFFF_FFFF);
         rd(16'hF240 + 16'(i * 16), rv);
         chk(rv, mask[i], "unimplemented bits");
         chk(mod_dis[i], mask[i], "gate output");
      end
      $display("done: masks");
   endtask : t_masks

   task automatic t_alias();
      wr(16'hF260, 32'h001F_0003);
      wr(16'hF264, 32'h0001_0001);
      chk(mod_dis[2], 32'h001E_0002, "clear alias");
      wr(16'hF268, 32'h0000_0010);
      chk(mod_dis[2], 32'h001E_0012, "set alias");
      wr(16'hF26C, 32'h0003_0003);
      chk(mod_dis[2], 32'h001D_0011, "invert alias");
      $display("done: aliases");
   endtask : t_alias

   task automatic t_lock();
      wr(`PMD_OFS_CONFIG_CONTROL_REG, 32'h0000_1000);
      chk({31'h0, wr_lock}, 32'h0, "lock without key");
      unlock();
      wr(`PMD_OFS_CONFIG_CONTROL_REG, 32'h0000_1000);
      rd(`PMD_OFS_CONFIG_CONTROL_REG, rv);
      chk(rv, 32'h0000_1000, "lock bit 12");
      wr(16'hF240, 32'h0000_0001);
      wr(16'hF248, 32'h0000_0010);
      rd(16'hF240, rv);
      chk(rv, 32'h0000_1101, "locked write");
      unlock();
      wr(`PMD_OFS_CONFIG_CONTROL_REG, 32'h0000_0000);
      chk({31'h0, wr_lock}, 32'h0, "lock cleared");
      wr(16'hF240, 32'h0000_0000);
      chk(mod_dis[0], 32'h0, "unlocked write");
      $display("done: lock");
   endtask : t_lock

   task automatic t_one_way();
      one_way <= 1'b1;
      repeat (3) @(posedge clk_i);
      unlock();
      wr(`PMD_OFS_CONFIG_CONTROL_REG, 32'h0000_1000);
      unlock();
      wr(`PMD_OFS_CONFIG_CONTROL_REG, 32'h0000_0000);
      chk({31'h0, wr_lock}, 32'h1, "sticky lock");
      wr(16'hF250, 32'h0000_0002);
      chk(mod_dis[1], 32'h0000_0007, "sticky blocks write");
      do_reset();
      #1 chk({31'h0, wr_lock}, 32'h0, "reset clears lock");
      chk(mod_dis[1], 32'h0, "reset clears register");
      wr(16'hF250, 32'h0000_0002);
      chk(mod_dis[1], 32'h0000_0002, "write after reset");
      $display("done: one-way option");
   endtask : t_one_way

   task automatic conclude();
      $display("compared %0d, mismatches %0d", n_compared, failures);
      if (failures == 0 && n_compared > 0) $display("Run complete: PASS");
      else $display("Run complete: FAIL");
      $finish;
   endtask : conclude

   // free-running clock
   initial begin
      clk_i = 1'b0;
      forever #5 clk_i = ~clk_i;
   end

   // main sequence
   initial begin
      rst_i = 1'b1;
      req_i = '0;
      one_way = 1'b0;
      failures = 0;
      n_compared = 0;
      mask = {`PMD_MASK_MISC, `PMD_MASK_SERIAL, `PMD_MASK_TIMERS, `PMD_MASK_CAPCOMP,
              `PMD_MASK_COMPARATORS, `PMD_MASK_ANALOG};
      do_reset();
      t_reset();
      t_masks();
      t_alias();
      t_lock();
      t_one_way();
      conclude();
   end

   // hang guard, far beyond the scenario length
   initial begin
      repeat (20000) @(posedge clk_i);
      failures++;
      $display("[FAIL] %0t run did not finish", $time);
      conclude();
   end
endmodule : pmd_lock_regs_test
